// *** verilog/mac_unit_pkg.sv ***
// Purpose: Shared constants and types of the multiply-accumulate unit
// Assumes: 32-bit classic Wishbone register access, byte addressing
// Notes:   Offsets are byte addresses on word boundaries

package mac_unit_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SEL_W = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FIRST_OPERAND = 8'h00;
  localparam logic [7:0] OFS_SECOND_OPERAND = 8'h04;
  localparam logic [7:0] OFS_ADDEND = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0c;
  localparam logic [7:0] OFS_DEST_LOWER = 8'h10;
  localparam logic [7:0] OFS_DEST_UPPER = 8'h14;
  localparam logic [7:0] OFS_STATUS_WORD = 8'h18;
  localparam logic [7:0] OFS_COMMAND = 8'h1c;
  localparam logic [7:0] OFS_UNIT_STATE = 8'h20;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned HALF_W = 16;
  localparam int unsigned HALF_TOP_LSB = 16;
  localparam int unsigned WORD_HALF_DROP = 16;
  localparam int unsigned STATE_BAD_OP_BIT = 16;

  // ----------------------------------------------------------------
  // Operation selection
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_LOW_PRODUCT = 4'h0,
    OP_PRODUCT_PLUS_ADDEND = 4'h1,
    OP_ADDEND_MINUS_PRODUCT = 4'h2,
    OP_UNSIGNED_WIDE_PRODUCT = 4'h3,
    OP_UNSIGNED_WIDE_ACC = 4'h4,
    OP_UNSIGNED_WIDE_DUAL_ACC = 4'h5,
    OP_SIGNED_HALFWORD_MAC = 4'h6,
    OP_SIGNED_WORD_BY_HALF_MAC = 4'h7,
    OP_SIGNED_DUAL_HALF_MAC = 4'h8
  } op_t;

  // Command word, written to launch one operation
  typedef struct packed {
    logic [20:0] unused;
    logic cond_fail;
    logic dest_omit;
    logic set_flags;
    logic crossed;
    logic second_top;
    logic first_top;
    logic [3:0] op;
  } cmd_t;

  // Program status word layout
  typedef struct packed {
    logic neg;
    logic zero;
    logic carry;
    logic ovf;
    logic sat;
    logic [26:0] unused;
  } psw_t;

endpackage

// *** verilog/half_multiplier.sv ***
// Purpose: Signed 16 x 16 multiplier giving a 32-bit product
// Assumes: Both halfwords are two's complement
// Notes:   Purely combinational, used twice by the unit

`timescale 1ns/100ps
`default_nettype none

module half_multiplier #(
  parameter int unsigned W = 16
) (
  // Operands
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  // Product
  output logic [2*W-1:0] p_o
);

  logic signed [2*W-1:0] a_ext;
  logic signed [2*W-1:0] b_ext;

  // Sign extend so the product wraps correctly at 2W bits
  assign a_ext = {{W{a_i[W-1]}}, a_i};
  assign b_ext = {{W{b_i[W-1]}}, b_i};
  assign p_o = a_ext * b_ext;

endmodule

`default_nettype wire

// *** verilog/mac_unit.sv ***
// Purpose: Integer multiply and multiply-accumulate datapath
// Assumes: Classic Wishbone slave, one operation per command write
// Notes:   A command executes at the edge that completes its write
//
// How it works
// - Low product writes bottom 32 bits of first times second operand.
// - Product plus addend writes the low 32 bits of that sum.
// - Addend minus product writes the low 32 bits of the difference.
// - These 32-bit results ignore signedness; one datapath serves both.
// - Omitted destination sends low product or halfword result to first operand.
// - Flag-setting low product updates negative and zero, keeps carry, overflow.
// - Unsigned wide product splits 64 bits into lower and upper words.
// - Wide dual accumulate adds both destination words to the product.
// - Wide accumulate adds the 64-bit destination pair to the product.
// - Unsigned wide forms never touch the condition flags.
// - Halfword selector picks bits 15:0 for bottom, 31:16 for top.
// - Halfword mac multiplies selected signed halves and adds the addend.
// - Word by half keeps the top 32 of 48 product bits, adds addend.
// - Top suffix picks second operand upper half, bottom its lower half.
// - Halfword and word-by-half accumulate overflow sets the saturation flag.
// - Uncrossed dual mac multiplies top by top and bottom by bottom.
// - Crossed dual mac multiplies first top by second bottom and vice versa.
// - Dual mac adds both products to the signed addend.

`timescale 1ns/100ps
`default_nettype none

module mac_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0] first_operand_reg;
  logic [31:0] second_operand_reg;
  logic [31:0] addend_reg;
  logic [31:0] result_reg;
  logic [31:0] dest_lower_word_reg;
  logic [31:0] dest_upper_word_reg;
  mac_unit_pkg::psw_t program_status_word_reg;
  logic bad_op_reg;
  logic [15:0] exec_count_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic req;
  logic wr_take;
  logic [7:0] word_adr;
  logic [31:0] wdata_merge_src;
  mac_unit_pkg::cmd_t cmd;
  logic run;

  // A request is live while cycle and strobe are high
  assign req = wb_cyc_i & wb_stb_i;
  // Writes land at the edge where the master sees ack
  assign wr_take = req & wb_we_i & ack_reg;
  // Word aligned address, low bits ignored
  assign word_adr = {wb_adr_i[7:2], 2'b00};
  assign wdata_merge_src = wb_dat_i;
  assign cmd = mac_unit_pkg::cmd_t'(wb_dat_i);
  // A command launches only when its condition holds
  assign run = wr_take & (word_adr == mac_unit_pkg::OFS_COMMAND) & ~cmd.cond_fail;

  // Byte-lane merge of write data into an old word
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Signed 32-bit add overflow detection
  function automatic logic add_ovf(input logic [31:0] a, input logic [31:0] b,
                                   input logic [31:0] s);
    return (a[31] == b[31]) && (s[31] != a[31]);
  endfunction

  // ----------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------
  logic [15:0] first_top_half;
  logic [15:0] first_bot_half;
  logic [15:0] second_top_half;
  logic [15:0] second_bot_half;
  logic [15:0] first_sel_half;
  logic [15:0] second_sel_half;
  logic [15:0] mul_a_a;
  logic [15:0] mul_a_b;
  logic [15:0] mul_b_a;
  logic [15:0] mul_b_b;
  logic [31:0] prod_a;
  logic [31:0] prod_b;
  logic is_dual;

  // Split both operands into halfwords
  assign first_top_half = first_operand_reg[mac_unit_pkg::HALF_TOP_LSB +: mac_unit_pkg::HALF_W];
  assign first_bot_half = first_operand_reg[mac_unit_pkg::HALF_W-1:0];
  assign second_top_half = second_operand_reg[mac_unit_pkg::HALF_TOP_LSB +: mac_unit_pkg::HALF_W];
  assign second_bot_half = second_operand_reg[mac_unit_pkg::HALF_W-1:0];

  // Halfword selectors for the single-product forms
  assign first_sel_half = cmd.first_top ? first_top_half : first_bot_half;
  assign second_sel_half = cmd.second_top ? second_top_half : second_bot_half;

  assign is_dual = (cmd.op == mac_unit_pkg::OP_SIGNED_DUAL_HALF_MAC);

  // Multiplier A: the selected halves, or in dual mode first top half against second top or bottom half
  assign mul_a_a = is_dual ? first_top_half : first_sel_half;
  assign mul_a_b = is_dual ? (cmd.crossed ? second_bot_half : second_top_half)
                           : second_sel_half;
  // Multiplier B: first bottom half against the remaining half
  assign mul_b_a = first_bot_half;
  assign mul_b_b = cmd.crossed ? second_top_half : second_bot_half;

  half_multiplier #(
    .W(mac_unit_pkg::HALF_W)
  ) u_mul_a (
    .a_i(mul_a_a),
    .b_i(mul_a_b),
    .p_o(prod_a)
  );

  half_multiplier #(
    .W(mac_unit_pkg::HALF_W)
  ) u_mul_b (
    .a_i(mul_b_a),
    .b_i(mul_b_b),
    .p_o(prod_b)
  );

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  logic [63:0] wide_prod;
  logic [31:0] low_prod;
  logic [31:0] plus_sum;
  logic [31:0] minus_diff;
  logic [63:0] wide_acc;
  logic [63:0] wide_dual_acc;
  logic [31:0] half_sum;
  logic half_ovf;
  logic signed [47:0] word_half_prod;
  logic [31:0] word_half_top;
  logic [31:0] word_half_sum;
  logic word_half_ovf;
  logic [31:0] dual_sum;

  // Unsigned 64-bit product; its low word equals the signed low word
  assign wide_prod = {32'h0000_0000, first_operand_reg} * {32'h0000_0000, second_operand_reg};
  assign low_prod = wide_prod[31:0];
  assign plus_sum = low_prod + addend_reg;
  assign minus_diff = addend_reg - low_prod;

  // Wide accumulations wrap modulo 2^64
  assign wide_acc = wide_prod + {dest_upper_word_reg, dest_lower_word_reg};
  // Two 32-bit addends cannot overflow the 64-bit sum
  assign wide_dual_acc = wide_prod + {32'h0000_0000, dest_upper_word_reg}
                       + {32'h0000_0000, dest_lower_word_reg};

  // Halfword mac, overflow caught on the accumulate only
  assign half_sum = prod_a + addend_reg;
  assign half_ovf = add_ovf(prod_a, addend_reg, half_sum);

  // Word by halfword: 48-bit product, lowest 16 bits dropped
  assign word_half_prod = $signed({{16{first_operand_reg[31]}}, first_operand_reg})
                        * $signed({{32{second_sel_half[15]}}, second_sel_half});
  assign word_half_top = word_half_prod[47:mac_unit_pkg::WORD_HALF_DROP];
  assign word_half_sum = word_half_top + addend_reg;
  assign word_half_ovf = add_ovf(word_half_top, addend_reg, word_half_sum);

  // Dual halfword mac wraps at 32 bits
  assign dual_sum = prod_a + prod_b + addend_reg;

  // ----------------------------------------------------------------
  // Result routing
  // ----------------------------------------------------------------
  logic single_valid;
  logic [31:0] single_res;
  logic wide_valid;
  logic [63:0] wide_res;
  logic omit_ok;
  logic q_hit;

  // Pick the result of the launched operation
  always_comb begin
    single_valid = 1'b0;
    single_res = mac_unit_pkg::RST_WORD;
    wide_valid = 1'b0;
    wide_res = {mac_unit_pkg::RST_WORD, mac_unit_pkg::RST_WORD};
    omit_ok = 1'b0;
    q_hit = 1'b0;
    case (cmd.op)
      mac_unit_pkg::OP_LOW_PRODUCT: begin
        single_valid = 1'b1;
        single_res = low_prod;
        omit_ok = 1'b1;
      end
      mac_unit_pkg::OP_PRODUCT_PLUS_ADDEND: begin
        single_valid = 1'b1;
        single_res = plus_sum;
      end
      mac_unit_pkg::OP_ADDEND_MINUS_PRODUCT: begin
        single_valid = 1'b1;
        single_res = minus_diff;
      end
      mac_unit_pkg::OP_UNSIGNED_WIDE_PRODUCT: begin
        wide_valid = 1'b1;
        wide_res = wide_prod;
      end
      mac_unit_pkg::OP_UNSIGNED_WIDE_ACC: begin
        wide_valid = 1'b1;
        wide_res = wide_acc;
      end
      mac_unit_pkg::OP_UNSIGNED_WIDE_DUAL_ACC: begin
        wide_valid = 1'b1;
        wide_res = wide_dual_acc;
      end
      mac_unit_pkg::OP_SIGNED_HALFWORD_MAC: begin
        single_valid = 1'b1;
        single_res = half_sum;
        omit_ok = 1'b1;
        q_hit = half_ovf;
      end
      mac_unit_pkg::OP_SIGNED_WORD_BY_HALF_MAC: begin
        single_valid = 1'b1;
        single_res = word_half_sum;
        q_hit = word_half_ovf;
      end
      mac_unit_pkg::OP_SIGNED_DUAL_HALF_MAC: begin
        single_valid = 1'b1;
        single_res = dual_sum;
      end
      default: begin
        single_valid = 1'b0;
      end
    endcase
  end

  logic to_first;
  logic to_result;

  // Omitted destination redirects to the first operand register
  assign to_first = run & single_valid & omit_ok & cmd.dest_omit;
  assign to_result = run & single_valid & ~(omit_ok & cmd.dest_omit);

  // ----------------------------------------------------------------
  // Operand registers
  // ----------------------------------------------------------------
  // First operand: bus write or redirected result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_operand_reg <= mac_unit_pkg::RST_WORD;
    end else if (to_first) begin
      first_operand_reg <= single_res;
    end else if (wr_take && word_adr == mac_unit_pkg::OFS_FIRST_OPERAND) begin
      first_operand_reg <= merge(first_operand_reg, wdata_merge_src, wb_sel_i);
    end
  end

  // Second operand: bus write only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      second_operand_reg <= mac_unit_pkg::RST_WORD;
    end else if (wr_take && word_adr == mac_unit_pkg::OFS_SECOND_OPERAND) begin
      second_operand_reg <= merge(second_operand_reg, wdata_merge_src, wb_sel_i);
    end
  end

  // Addend: bus write only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addend_reg <= mac_unit_pkg::RST_WORD;
    end else if (wr_take && word_adr == mac_unit_pkg::OFS_ADDEND) begin
      addend_reg <= merge(addend_reg, wdata_merge_src, wb_sel_i);
    end
  end

  // ----------------------------------------------------------------
  // Destination registers
  // ----------------------------------------------------------------
  // 32-bit result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_reg <= mac_unit_pkg::RST_WORD;
    end else if (to_result) begin
      result_reg <= single_res;
    end else if (wr_take && word_adr == mac_unit_pkg::OFS_RESULT) begin
      result_reg <= merge(result_reg, wdata_merge_src, wb_sel_i);
    end
  end

  // Lower destination word, also an accumulate source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dest_lower_word_reg <= mac_unit_pkg::RST_WORD;
    end else if (run && wide_valid) begin
      dest_lower_word_reg <= wide_res[31:0];
    end else if (wr_take && word_adr == mac_unit_pkg::OFS_DEST_LOWER) begin
      dest_lower_word_reg <= merge(dest_lower_word_reg, wdata_merge_src, wb_sel_i);
    end
  end

  // Upper destination word, also an accumulate source
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dest_upper_word_reg <= mac_unit_pkg::RST_WORD;
    end else if (run && wide_valid) begin
      dest_upper_word_reg <= wide_res[63:32];
    end else if (wr_take && word_adr == mac_unit_pkg::OFS_DEST_UPPER) begin
      dest_upper_word_reg <= merge(dest_upper_word_reg, wdata_merge_src, wb_sel_i);
    end
  end

  // ----------------------------------------------------------------
  // Program status word
  // ----------------------------------------------------------------
  logic flag_upd;

  // Only the flag-setting low product touches negative and zero
  assign flag_upd = run & cmd.set_flags & (cmd.op == mac_unit_pkg::OP_LOW_PRODUCT);

  // Negative, zero and saturation from results; wide forms leave all alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      program_status_word_reg <= mac_unit_pkg::psw_t'(mac_unit_pkg::RST_WORD);
    end else if (wr_take && word_adr == mac_unit_pkg::OFS_STATUS_WORD) begin
      program_status_word_reg <= mac_unit_pkg::psw_t'(merge(program_status_word_reg,
                                                            wdata_merge_src, wb_sel_i));
      program_status_word_reg.unused <= '0;
    end else begin
      if (flag_upd) begin
        program_status_word_reg.neg <= low_prod[31];
        program_status_word_reg.zero <= (low_prod == mac_unit_pkg::RST_WORD);
      end
      if (run && q_hit) begin
        program_status_word_reg.sat <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Unit state
  // ----------------------------------------------------------------
  // Unknown operation codes are flagged and do nothing else
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bad_op_reg <= 1'b0;
    end else if (run) begin
      bad_op_reg <= ~(single_valid | wide_valid);
    end
  end

  // Count of executed commands, wrapping
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exec_count_reg <= mac_unit_pkg::RST_COUNT;
    end else if (run && (single_valid || wide_valid)) begin
      exec_count_reg <= exec_count_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Read data captured together with ack; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= mac_unit_pkg::RST_WORD;
    end else if (req && !ack_reg) begin
      case (word_adr)
        mac_unit_pkg::OFS_FIRST_OPERAND: rdata_reg <= first_operand_reg;
        mac_unit_pkg::OFS_SECOND_OPERAND: rdata_reg <= second_operand_reg;
        mac_unit_pkg::OFS_ADDEND: rdata_reg <= addend_reg;
        mac_unit_pkg::OFS_RESULT: rdata_reg <= result_reg;
        mac_unit_pkg::OFS_DEST_LOWER: rdata_reg <= dest_lower_word_reg;
        mac_unit_pkg::OFS_DEST_UPPER: rdata_reg <= dest_upper_word_reg;
        mac_unit_pkg::OFS_STATUS_WORD: rdata_reg <= program_status_word_reg;
        mac_unit_pkg::OFS_UNIT_STATE: rdata_reg <= {15'h0000, bad_op_reg, exec_count_reg};
        default: rdata_reg <= mac_unit_pkg::RST_WORD;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

endmodule

`default_nettype wire

// *** bench/mac_unit_assertions.sv ***
// Purpose: Bus-side checks of the multiply-accumulate unit
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every instance of the unit
`timescale 1ns/100ps
`default_nettype none
module mac_unit_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave pins
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken this cycle, and word-aligned address of it
  logic req;
  logic rd_req;
  logic [7:0] wadr;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_req = req && !wb_we_i;
  assign wadr = {wb_adr_i[7:2], 2'b00};
  AST_ACK_AFTER_REQ: assert property (req |=> wb_ack_o) else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_NO_STRAY_ACK: assert property (!req |=> !wb_ack_o) else $error("ack without request");
  AST_DATA_HOLDS: assert property (!req |=> $stable(wb_dat_o)) else $error("read data moved while idle");
  AST_CMD_READS_ZERO: assert property (rd_req && wadr == mac_unit_pkg::OFS_COMMAND |=> wb_dat_o == 32'h0)
    else $error("command register read not zero");
  AST_PSW_SPARE_ZERO: assert property (rd_req && wadr == mac_unit_pkg::OFS_STATUS_WORD |=> wb_dat_o[26:0] == 27'h0)
    else $error("status word spare bits not zero");
  AST_UNMAPPED_ZERO: assert property (rd_req && wb_adr_i[7:2] > 6'h08 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_RESET_QUIET: assert property (@(posedge clk_i) disable iff (1'b0) rst_i |=> !wb_ack_o && wb_dat_o == 32'h0)
    else $error("bus not quiet in reset");
  // Main scenarios
  cover property (req && wb_we_i && wadr == mac_unit_pkg::OFS_COMMAND);
  cover property (rd_req && wadr == mac_unit_pkg::OFS_RESULT);
  cover property (rd_req && wb_adr_i[7:2] > 6'h08);
endmodule
bind mac_unit mac_unit_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o));
`default_nettype wire

// *** bench/mac_issuer_model.sv ***
// Purpose: Issuing side of the unit, a classic Wishbone master
// Assumes: Fixed registers, so no stack pointer, program counter or aliasing
// Notes: kept by the fixed register map used here
`timescale 1ns/100ps
`default_nettype none
module mac_issuer_model (
  // Clock
  input wire logic clk_i,
  // Wishbone master pins
  output logic wb_cyc_o = 1'b0,
  output logic wb_stb_o = 1'b0,
  output logic wb_we_o = 1'b0,
  output logic [7:0] wb_adr_o = 8'h00,
  output logic [3:0] wb_sel_o = 4'hf,
  output logic [31:0] wb_dat_o = 32'h0,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  // One classic cycle; released lines show inverted leftovers
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] m,
                      output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_sel_o <= m;
    wb_dat_o <= d;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_adr_o <= ~a;
    wb_sel_o <= ~m;
    wb_dat_o <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, 4'hf, q);
  endtask
  // Write with chosen byte lanes
  task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] m);
    logic [31:0] q;
    xfer(1'b1, a, d, m, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, 4'hf, q);
  endtask
endmodule
`default_nettype wire

// *** bench/mac_unit_tb.sv ***
// Purpose: Self-checking bench of the multiply-accumulate unit
// Assumes: Reference model below, random operands from a fixed seed
// Notes:   Every operation code, plus one unknown code, is exercised
`timescale 1ns/100ps
`default_nettype none
module mac_unit_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  int miscompares = 0;
  int total_checks = 0;
  int seed = 72;
  logic [31:0] a, b, c, r, dl, dh, ps, g, ea, er, edl, edh, ep, v, v2, s;
  logic [47:0] w;
  logic [15:0] ha, hb;
  logic [3:0] m;
  logic [15:0] cnt = 16'h0000;
  logic bad = 1'b0;
  mac_unit_pkg::cmd_t cmd;
  // Clock
  always #5 clk_i = ~clk_i;
  mac_unit dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  mac_issuer_model host (.clk_i(clk_i), .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i),
    .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i), .wb_dat_i(wb_dat_o), .wb_ack_i(wb_ack_o));
  // Compare and verdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] q);
    total_checks++;
    if (q !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, q);
    end
  endtask
  task automatic summarize;
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    host.rd(mac_unit_pkg::OFS_RESULT, g);
    chk("result after reset", 32'h0, g);
    host.rd(8'h40, g);
    chk("unmapped read", 32'h0, g);
    er = 32'h0;
    for (int i = 0; i < 60; i++) begin
      a = $random(seed); b = $random(seed); c = $random(seed);
      r = $random(seed); dl = $random(seed); dh = $random(seed);
      ps = $random(seed);
      m = 4'($random(seed));
      cmd = $random(seed);
      cmd.op = 4'(i % 10);
      cmd.cond_fail = cmd.cond_fail & cmd.dest_omit & !cmd.set_flags;
      host.wr(mac_unit_pkg::OFS_FIRST_OPERAND, a);
      host.wr(mac_unit_pkg::OFS_SECOND_OPERAND, b);
      host.wr(mac_unit_pkg::OFS_ADDEND, c);
      // Only the enabled byte lanes of the result take the new value
      for (int k = 0; k < 4; k++) begin
        if (m[k]) er[8*k +: 8] = r[8*k +: 8];
      end
      host.wrs(mac_unit_pkg::OFS_RESULT, r, m);
      host.wr(mac_unit_pkg::OFS_DEST_LOWER, dl);
      host.wr(mac_unit_pkg::OFS_DEST_UPPER, dh);
      host.wr(mac_unit_pkg::OFS_STATUS_WORD, ps);
      host.wr(mac_unit_pkg::OFS_COMMAND, 32'(cmd));
      host.rd(mac_unit_pkg::OFS_COMMAND, g);
      chk("command reads zero", 32'h0, g);
      // Reference model of one command
      ea = a; edl = dl; edh = dh; ep = ps & 32'hf800_0000;
      ha = cmd.first_top ? a[31:16] : a[15:0];
      hb = cmd.second_top ? b[31:16] : b[15:0];
      if (!cmd.cond_fail) case (cmd.op)
        4'h0: begin
          v = a * b;
          if (cmd.dest_omit) ea = v; else er = v;
          if (cmd.set_flags) begin
            ep[31] = v[31];
            ep[30] = (v == 32'h0);
          end
        end
        4'h1: er = a * b + c;
        4'h2: er = c - a * b;
        4'h3: {edh, edl} = {32'h0, a} * {32'h0, b};
        4'h4: {edh, edl} = {32'h0, a} * {32'h0, b} + {dh, dl};
        4'h5: {edh, edl} = {32'h0, a} * {32'h0, b} + {32'h0, dh} + {32'h0, dl};
        4'h6, 4'h7: begin
          v = $signed(ha) * $signed(hb);
          w = $signed(a) * $signed(hb);
          if (cmd.op == 4'h7) v = w[47:16];
          s = v + c;
          if (v[31] == c[31] && s[31] != v[31]) ep[27] = 1'b1;
          if (cmd.op == 4'h6 && cmd.dest_omit) ea = s; else er = s;
        end
        4'h8: begin
          v = $signed(a[31:16]) * $signed(cmd.crossed ? b[15:0] : b[31:16]);
          v2 = $signed(a[15:0]) * $signed(cmd.crossed ? b[31:16] : b[15:0]);
          er = v + v2 + c;
        end
        default: ;
      endcase
      // Unit state: bad-op bit and count of executed commands
      if (!cmd.cond_fail) begin
        bad = (cmd.op == 4'h9);
        cnt = cnt + {15'h0000, !bad};
      end
      host.rd(mac_unit_pkg::OFS_FIRST_OPERAND, g);
      chk("first operand", ea, g);
      host.rd(mac_unit_pkg::OFS_RESULT, g);
      chk("result", er, g);
      host.rd(mac_unit_pkg::OFS_DEST_LOWER, g);
      chk("dest lower", edl, g);
      host.rd(mac_unit_pkg::OFS_DEST_UPPER, g);
      chk("dest upper", edh, g);
      host.rd(mac_unit_pkg::OFS_STATUS_WORD, g);
      chk("status word", ep, g);
      host.rd(mac_unit_pkg::OFS_UNIT_STATE, g);
      chk("unit state", {15'h0000, bad, cnt}, g);
      if (cmd.op == 4'h9 && !cmd.cond_fail) begin
        host.rd(mac_unit_pkg::OFS_UNIT_STATE, g);
        chk("bad op flag", 32'h1, {31'h0, g[16]});
      end
    end
    summarize();
  end
endmodule
`default_nettype wire
